// File: svld_pkg.sv
package svld_pkg;
    // register map (byte addresses on the internal register port)
    localparam logic [3:0] SVLD_ADDR_CTRL   = 4'h0;
    localparam logic [3:0] SVLD_ADDR_STAT   = 4'h1;
    localparam logic [3:0] SVLD_ADDR_IRQ_ST = 4'h2;
    localparam logic [3:0] SVLD_ADDR_IRQ_MK = 4'h3;
    localparam int SVLD_ADDR_W = 4;
    localparam int SVLD_DATA_W = 8;

    // control register fields
    localparam int SVLD_CTRL_RANGE_BIT = 3;
    localparam int SVLD_CTRL_TRIM_LSB  = 0;
    localparam int SVLD_TRIM_W         = 3;
    localparam logic       SVLD_RANGE_RST = 1'b0;
    localparam logic [2:0] SVLD_TRIM_RST  = 3'h0;

    // status register fields
    localparam int SVLD_STAT_RESULT_BIT = 2;
    localparam int SVLD_STAT_READY_BIT  = 1;
    localparam int SVLD_STAT_ON_BIT     = 0;
    localparam logic SVLD_ON_RST     = 1'b0;
    localparam logic SVLD_READY_RST  = 1'b0;
    localparam logic SVLD_RESULT_RST = 1'b0;

    // interrupt status / mask layout
    localparam int SVLD_IRQ_LOW_BIT = 0;
    localparam logic SVLD_IRQ_MASK_RST = 1'b0;

    // timing
    localparam longint SVLD_CLK_HZ      = 10_000_000;
    localparam longint SVLD_SETTLE_US   = 2000;
    localparam longint SVLD_PULSE_MAX_US = 1350;
    localparam longint SVLD_SETTLE_CYC  =
        (SVLD_SETTLE_US * SVLD_CLK_HZ) / 1_000_000;
    // filter length below the longest guaranteed pulse (round down)
    localparam longint SVLD_PULSE_CYC   =
        (SVLD_PULSE_MAX_US * SVLD_CLK_HZ) / 1_000_000 / 2;
    localparam int SVLD_CNT_W = 16;

    typedef enum logic [1:0] {
        SVLD_OFF,
        SVLD_SETTLING,
        SVLD_READY
    } svld_state_t;
endpackage

// File: svld_meas_if.sv
`timescale 1ns/1ns
interface svld_meas_if;
    logic start;
    logic stop;
    logic ready;
    logic comp_raw;
    logic result;
    logic rise;
    modport ctrl (output start, output stop, input ready,
                  input result, input rise);
    modport meas (input start, input stop, output ready,
                  input comp_raw, output result, output rise);
endinterface

// File: svld_meas.sv
`timescale 1ns/1ns
module svld_meas
    import svld_pkg::*;
#(
    parameter int SETTLE_CYC = int'(SVLD_SETTLE_CYC),
    parameter int PULSE_CYC  = int'(SVLD_PULSE_CYC)
) (
    input  wire logic   clk,
    input  wire logic   reset,
    svld_meas_if.meas   m
);
    svld_state_t              state_q, state_d;
    logic [SVLD_CNT_W-1:0]    cnt_q, cnt_d;
    logic [SVLD_CNT_W-1:0]    flt_q, flt_d;
    logic                     res_q, res_d;
    logic                     rise_q, rise_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        flt_d   = flt_q;
        res_d   = res_q;
        rise_d  = 1'b0;
        unique case (state_q)
            SVLD_OFF: begin
                if (m.start) begin
                    state_d = SVLD_SETTLING;
                    cnt_d   = '0;
                end
            end
            SVLD_SETTLING: begin
                if (cnt_q == SVLD_CNT_W'(SETTLE_CYC - 1)) begin
                    // counted in clk cycles, so it scales with the clock
                    state_d = SVLD_READY;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            SVLD_READY: begin
                // a dip must persist for the filter length; shorter
                // glitches may be missed, longer ones never are
                if (!m.comp_raw) begin
                    flt_d = '0;
                    res_d = 1'b0;
                end else if (flt_q == SVLD_CNT_W'(PULSE_CYC - 1)) begin
                    res_d  = 1'b1;
                    rise_d = !res_q;
                end else begin
                    flt_d = flt_q + 1'b1;
                end
            end
        endcase
        if (m.stop) begin
            state_d = SVLD_OFF;
            res_d   = 1'b0;
            flt_d   = '0;
            rise_d  = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= SVLD_OFF;
            cnt_q   <= '0;
            flt_q   <= '0;
            res_q   <= SVLD_RESULT_RST;
            rise_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            flt_q   <= flt_d;
            res_q   <= res_d;
            rise_q  <= rise_d;
        end
    end

    assign m.ready  = (state_q == SVLD_READY);
    assign m.result = res_q;
    assign m.rise   = rise_q;
endmodule

// File: svld_top.sv
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ns
// Function
// - control bit 3 picks low or high threshold range, resets 0
// - control bits 2:0 trim threshold in eight steps, reset 000
// - status bit 2 reads 1 while supply has stayed below threshold for the filter length, once ready
// - status bit 1 shows result holds a valid measurement
// - status bit 0 switches the detector on and off
// - enabling starts a measurement; ready rises after 2 ms settling
// - once ready and while enabled, low supply requests a maskable irq
// - one interrupt request on every rising edge of the result
// - once ready, dips of at least the longest pulse figure are always caught
// - timings hold for the nominal clock and scale with it
// - once ready, result goes high when supply stays below the threshold for the filter length
module svld_top
    import svld_pkg::*;
#(
    parameter int SETTLE_CYC = int'(SVLD_SETTLE_CYC),
    parameter int PULSE_CYC  = int'(SVLD_PULSE_CYC)
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic [SVLD_ADDR_W-1:0] addr,
    input  wire logic [SVLD_DATA_W-1:0] wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [SVLD_DATA_W-1:0] rdata,
    input  wire logic                   comp_below,
    output logic                        threshold_range_sel,
    output logic      [SVLD_TRIM_W-1:0] threshold_trim,
    output logic                        comparator_power,
    output logic                        low_supply_irq
);
    // comparator output is asynchronous to clk
    logic                   comp_s1_q, comp_s2_q;
    logic                   range_q, range_d;
    logic [SVLD_TRIM_W-1:0] trim_q, trim_d;
    logic                   on_q, on_d;
    logic                   ist_q, ist_d;
    logic                   imk_q, imk_d;
    logic [SVLD_DATA_W-1:0] rdata_d;
    logic                   irq_d;

    svld_meas_if mif ();

    svld_meas #(
        .SETTLE_CYC (SETTLE_CYC),
        .PULSE_CYC  (PULSE_CYC)
    ) u_meas (
        .clk   (clk),
        .reset (reset),
        .m     (mif)
    );

    assign mif.comp_raw = comp_s2_q;

    function automatic logic hit(input logic [SVLD_ADDR_W-1:0] a,
                                 input logic [SVLD_ADDR_W-1:0] r);
        return a == r;
    endfunction

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            comp_s1_q <= 1'b0;
            comp_s2_q <= 1'b0;
        end else begin
            comp_s1_q <= comp_below;
            comp_s2_q <= comp_s1_q;
        end
    end

    always_comb begin
        range_d = range_q;
        trim_d  = trim_q;
        on_d    = on_q;
        imk_d   = imk_q;
        ist_d   = ist_q;
        mif.start = 1'b0;
        mif.stop  = 1'b0;
        if (wr && hit(addr, SVLD_ADDR_CTRL)) begin
            range_d = wdata[SVLD_CTRL_RANGE_BIT];
            trim_d  = wdata[SVLD_CTRL_TRIM_LSB +: SVLD_TRIM_W];
        end
        if (wr && hit(addr, SVLD_ADDR_STAT)) begin
            on_d = wdata[SVLD_STAT_ON_BIT];
            mif.start = wdata[SVLD_STAT_ON_BIT] && !on_q;
            mif.stop  = !wdata[SVLD_STAT_ON_BIT];
        end
        if (wr && hit(addr, SVLD_ADDR_IRQ_MK)) begin
            imk_d = wdata[SVLD_IRQ_LOW_BIT];
        end
        // write-one-to-clear; a simultaneous new event wins
        if (wr && hit(addr, SVLD_ADDR_IRQ_ST) && wdata[SVLD_IRQ_LOW_BIT]) begin
            ist_d = 1'b0;
        end
        if (mif.rise && on_q && mif.ready) begin
            ist_d = 1'b1;
        end
    end

    always_comb begin
        rdata_d = '0;
        if (rd) begin
            unique case (addr)
                SVLD_ADDR_CTRL: begin
                    rdata_d[SVLD_CTRL_RANGE_BIT] = range_q;
                    rdata_d[SVLD_CTRL_TRIM_LSB +: SVLD_TRIM_W] = trim_q;
                end
                SVLD_ADDR_STAT: begin
                    rdata_d[SVLD_STAT_RESULT_BIT] = mif.result;
                    rdata_d[SVLD_STAT_READY_BIT]  = mif.ready;
                    rdata_d[SVLD_STAT_ON_BIT]     = on_q;
                end
                SVLD_ADDR_IRQ_ST: rdata_d[SVLD_IRQ_LOW_BIT] = ist_q;
                SVLD_ADDR_IRQ_MK: rdata_d[SVLD_IRQ_LOW_BIT] = imk_q;
                default:          rdata_d = '0;
            endcase
        end
        irq_d = ist_d && imk_d;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            range_q             <= SVLD_RANGE_RST;
            trim_q              <= SVLD_TRIM_RST;
            on_q                <= SVLD_ON_RST;
            ist_q               <= 1'b0;
            imk_q               <= SVLD_IRQ_MASK_RST;
            rdata               <= '0;
            low_supply_irq      <= 1'b0;
            threshold_range_sel <= SVLD_RANGE_RST;
            threshold_trim      <= SVLD_TRIM_RST;
            comparator_power    <= SVLD_ON_RST;
        end else begin
            range_q             <= range_d;
            trim_q              <= trim_d;
            on_q                <= on_d;
            ist_q               <= ist_d;
            imk_q               <= imk_d;
            rdata               <= rdata_d;
            low_supply_irq      <= irq_d;
            // timing counts follow clk directly, so they scale with it
            threshold_range_sel <= range_d;
            threshold_trim      <= trim_d;
            comparator_power    <= on_d;
        end
    end
endmodule

// File: svld_top_monitor.sv
`timescale 1ns/1ns
module svld_top_monitor
    import svld_pkg::*;
#(
    parameter int SETTLE_CYC = int'(SVLD_SETTLE_CYC),
    parameter int PULSE_CYC  = int'(SVLD_PULSE_CYC)
) (
    input wire logic                   clk,
    input wire logic                   reset,
    input wire logic [SVLD_ADDR_W-1:0] addr,
    input wire logic [SVLD_DATA_W-1:0] wdata,
    input wire logic                   wr,
    input wire logic                   rd,
    input wire logic [SVLD_DATA_W-1:0] rdata,
    input wire logic                   comp_below,
    input wire logic                   threshold_range_sel,
    input wire logic [SVLD_TRIM_W-1:0] threshold_trim,
    input wire logic                   comparator_power,
    input wire logic                   low_supply_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    wire c_wr = wr && addr == SVLD_ADDR_CTRL;
    wire s_wr = wr && addr == SVLD_ADDR_STAT;
    wire s_rd = rd && addr == SVLD_ADDR_STAT;

    ctrl_write_a: assert property (c_wr |=>
        {threshold_range_sel, threshold_trim} == $past(wdata[3:0]))
        else $error("control outputs did not follow write");
    ctrl_hold_a: assert property (!c_wr |=> $stable(threshold_trim)
        && $stable(threshold_range_sel)) else $error("control moved");
    enable_write_a: assert property (s_wr |=>
        comparator_power == $past(wdata[0])) else $error("enable lost");
    ctrl_read_a: assert property (rd && addr == SVLD_ADDR_CTRL |=>
        rdata == {4'h0, $past(threshold_range_sel), $past(threshold_trim)})
        else $error("control readback wrong");
    status_order_a: assert property (s_rd |=>
        (!rdata[2] || rdata[1]) && (!rdata[1] || rdata[0]))
        else $error("result or ready without its cause");
    enable_read_a: assert property (s_rd |=>
        rdata[0] == $past(comparator_power)) else $error("enable read");
    irq_cause_a: assert property ($rose(low_supply_irq) |->
        $past(comparator_power, 2) || $past(wr) || $past(wr, 2))
        else $error("interrupt without enabled detector");
    mask_off_a: assert property (wr && addr == SVLD_ADDR_IRQ_MK
        && !wdata[0] |-> ##[1:2] !low_supply_irq)
        else $error("masked interrupt still high");

    cover property ($rose(low_supply_irq));
    cover property (s_rd ##1 rdata[1]);
    cover property ($fell(comparator_power));
endmodule

// File: test_svld_top.sv
`timescale 1ns/1ns
module test_svld_top
    import svld_pkg::*;
;
    localparam int SC = 8;
    localparam int W  = 3 + 8;
    logic       clk, reset, wr, rd, comp_below, rng, pwr, irq;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [2:0] trim;
    int         err_count = 0;
    int         check_count = 0;

    svld_top #(.SETTLE_CYC(SC), .PULSE_CYC(3)) svld_top_inst (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .comp_below(comp_below),
        .threshold_range_sel(rng), .threshold_trim(trim),
        .comparator_power(pwr), .low_supply_irq(irq));

    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end

    task report_and_stop;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data live only in the cycle after the strobe
    task rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask

    task dip(input logic v);
        @(posedge clk);
        comp_below <= v;
        repeat (W) @(posedge clk);
    endtask

    initial begin
        #(100 * 4000);
        err_count++;
        report_and_stop;
    end

    initial begin
        reset = 1; wr = 0; rd = 0; addr = 0; wdata = 0; comp_below = 0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd_chk(SVLD_ADDR_CTRL, 8'h00);
        rd_chk(SVLD_ADDR_STAT, 8'h00);
        for (int i = 0; i < 16; i++) begin
            wr_reg(SVLD_ADDR_CTRL, 8'hF0 | 8'(i));
            rd_chk(SVLD_ADDR_CTRL, 8'(i));
            chk({4'h0, rng, trim}, 8'(i));
        end
        wr_reg(4'h7, 8'hFF);
        rd_chk(4'h7, 8'h00);
        wr_reg(SVLD_ADDR_IRQ_MK, 8'h01);
        comp_below <= 1'b1;
        wr_reg(SVLD_ADDR_STAT, 8'h01);
        // outputs launched on this edge settle after it
        #1 chk({7'h0, pwr}, 8'h01);
        // supply already low: result must wait for ready
        rd_chk(SVLD_ADDR_STAT, 8'h01);
        repeat (SC + W) @(posedge clk);
        rd_chk(SVLD_ADDR_STAT, 8'h07);
        rd_chk(SVLD_ADDR_IRQ_ST, 8'h01);
        chk({7'h0, irq}, 8'h01);
        wr_reg(SVLD_ADDR_IRQ_ST, 8'h01);
        dip(1'b1);
        #1 chk({7'h0, irq}, 8'h00);
        dip(1'b0);
        rd_chk(SVLD_ADDR_STAT, 8'h03);
        wr_reg(SVLD_ADDR_IRQ_MK, 8'h00);
        dip(1'b1);
        rd_chk(SVLD_ADDR_IRQ_ST, 8'h01);
        chk({7'h0, irq}, 8'h00);
        wr_reg(SVLD_ADDR_IRQ_MK, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk({7'h0, irq}, 8'h01);
        wr_reg(SVLD_ADDR_IRQ_ST, 8'h01);
        wr_reg(SVLD_ADDR_STAT, 8'h00);
        rd_chk(SVLD_ADDR_STAT, 8'h00);
        dip(1'b0);
        dip(1'b1);
        rd_chk(SVLD_ADDR_IRQ_ST, 8'h00);
        chk({7'h0, irq}, 8'h00);
        wr_reg(SVLD_ADDR_STAT, 8'h01);
        rd_chk(SVLD_ADDR_STAT, 8'h01);
        repeat (SC + W) @(posedge clk);
        rd_chk(SVLD_ADDR_STAT, 8'h07);
        chk({7'h0, irq}, 8'h01);
        // reset in mid-run while enabled with a pending interrupt
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd_chk(SVLD_ADDR_CTRL, 8'h00);
        rd_chk(SVLD_ADDR_STAT, 8'h00);
        chk({7'h0, irq}, 8'h00);
        report_and_stop;
    end
endmodule

bind svld_top svld_top_monitor #(.SETTLE_CYC(SETTLE_CYC),
    .PULSE_CYC(PULSE_CYC)) mon_inst (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .comp_below(comp_below), .threshold_range_sel(threshold_range_sel),
    .threshold_trim(threshold_trim), .comparator_power(comparator_power),
    .low_supply_irq(low_supply_irq));
